// >>> hdl/pin_function_select.sv
// Operation
// - Slave-select pin low in slave mode marks transfer for first serial port to receive.
// - After reset the slave-select pin takes its serial port function, not GPIO.
// - Clearing port E pull-up bit 7 disables pull-up on slave-select pin.
// - Clearing port C pull-up bit 0 or 1 disables phase A or B pull-up.
// - Phase-A alternate bit set routes second serial port clock onto phase A pin.
// - Phase-B alternate bit set routes second serial port data-out onto phase B pin.
// - Second port clock pin drives out as master, is clock input as slave.
// - Second port data-out pin is output as master, input as slave.
// - Master data leads slave sampling clock edge by half a clock period.
// - Large variant phase pins reset to decoder inputs; small variant needs configuration.
// - Each shared pin in GPIO use is individually input or output.
`timescale 1ns/1ps
`include "pin_function_defines.svh"

module pin_function_select #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input  logic       i_clock,
  input  logic       i_rst_b,
  // Local register write port
  input  logic       i_reg_we,
  input  logic [2:0] i_reg_sel,
  input  logic [7:0] i_reg_wdata,
  // Pads
  input  logic       i_ss_pad_in,
  output logic       o_ss_pad_out,
  output logic       o_ss_pad_oe,
  output logic       o_ss_pad_pullup_en,
  input  logic       i_phase_a_pad_in,
  output logic       o_phase_a_pad_out,
  output logic       o_phase_a_pad_oe,
  output logic       o_phase_a_pad_pullup_en,
  input  logic       i_phase_b_pad_in,
  output logic       o_phase_b_pad_out,
  output logic       o_phase_b_pad_oe,
  output logic       o_phase_b_pad_pullup_en,
  // First serial port
  input  logic       i_spi0_master,
  output logic       o_spi0_slave_select_pin_b,
  output logic       o_spi0_receive_en,
  // Second serial port
  input  logic       i_spi1_master,
  input  logic       i_spi1_sclk_out,
  input  logic       i_spi1_mosi_out,
  output logic       o_spi1_serial_clock_pin,
  output logic       o_spi1_data_out_pin,
  // Decoder and timer
  output logic       o_decoder1_phase_a_in,
  output logic       o_decoder1_phase_b_in,
  input  logic       i_timer_b_channel_0_out,
  input  logic       i_timer_b_channel_0_oe,
  input  logic       i_timer_b_channel_1_out,
  input  logic       i_timer_b_channel_1_oe,
  output logic       o_timer_b_channel_0,
  output logic       o_timer_b_channel_1,
  // GPIO pin levels
  output logic       o_port_e_line_7,
  output logic       o_port_c_line_0,
  output logic       o_port_c_line_1,
  // Register readback
  output logic [7:0] o_system_pin_select_reg,
  output logic [7:0] o_port_e_pullup_ctrl,
  output logic [7:0] o_port_c_pullup_ctrl,
  output logic [7:0] o_port_e_periph_en,
  output logic [7:0] o_port_c_periph_en,
  output logic [7:0] o_port_e_dir,
  output logic [7:0] o_port_c_dir,
  output logic [7:0] o_port_data,
  output logic [1:0] o_phase_pins_configured
);

  logic [7:0]                  pin_select_q;
  logic [7:0]                  port_e_pullup_q;
  logic [7:0]                  port_c_pullup_q;
  logic [7:0]                  port_e_periph_q;
  logic [7:0]                  port_c_periph_q;
  logic [7:0]                  port_e_dir_q;
  logic [7:0]                  port_c_dir_q;
  logic [7:0]                  port_data_q;
  logic [1:0]                  configured_q;
  pin_function_pkg::pin_func_e ss_func;
  pin_function_pkg::pin_func_e phase_a_func;
  pin_function_pkg::pin_func_e phase_b_func;

  function automatic logic reg_hit(input logic we, input logic [2:0] sel, input logic [2:0] code);
    reg_hit = we & (sel == code);
  endfunction : reg_hit

  function automatic pin_function_pkg::pin_func_e decode_func(input logic valid,
                                                              input logic periph,
                                                              input logic alt);
    if (!valid) begin
      decode_func = pin_function_pkg::FUNC_NONE;
    end else if (!periph) begin
      decode_func = pin_function_pkg::FUNC_GPIO;
    end else if (alt) begin
      decode_func = pin_function_pkg::FUNC_ALT_SPI;
    end else begin
      decode_func = pin_function_pkg::FUNC_PRIMARY;
    end
  endfunction : decode_func

  // Alternate selects start cleared
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      pin_select_q <= `PIN_SELECT_RESET;
    end else if (reg_hit(i_reg_we, i_reg_sel, `REG_SYSTEM_PIN_SELECT)) begin
      pin_select_q <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      port_e_pullup_q <= `PULLUP_RESET;
      port_c_pullup_q <= `PULLUP_RESET;
    end else begin
      if (reg_hit(i_reg_we, i_reg_sel, `REG_PORT_E_PULLUP)) begin
        port_e_pullup_q <= i_reg_wdata;
      end
      if (reg_hit(i_reg_we, i_reg_sel, `REG_PORT_C_PULLUP)) begin
        port_c_pullup_q <= i_reg_wdata;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      port_e_periph_q <= `PERIPH_RESET;
      port_c_periph_q <= `PERIPH_RESET;
    end else begin
      if (reg_hit(i_reg_we, i_reg_sel, `REG_PORT_E_PERIPH)) begin
        port_e_periph_q <= i_reg_wdata;
      end
      if (reg_hit(i_reg_we, i_reg_sel, `REG_PORT_C_PERIPH)) begin
        port_c_periph_q <= i_reg_wdata;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      port_e_dir_q <= `DIR_RESET;
      port_c_dir_q <= `DIR_RESET;
      port_data_q  <= `DATA_RESET;
    end else begin
      if (reg_hit(i_reg_we, i_reg_sel, `REG_PORT_E_DIR)) begin
        port_e_dir_q <= i_reg_wdata;
      end
      if (reg_hit(i_reg_we, i_reg_sel, `REG_PORT_C_DIR)) begin
        port_c_dir_q <= i_reg_wdata;
      end
      if (reg_hit(i_reg_we, i_reg_sel, `REG_PORT_DATA)) begin
        port_data_q <= i_reg_wdata;
      end
    end
  end

  // Small variant leaves phase pins unassigned until software writes a selection
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      configured_q <= {2{LARGE_VARIANT}};
    end else if (reg_hit(i_reg_we, i_reg_sel, `REG_PORT_C_PERIPH) ||
                 reg_hit(i_reg_we, i_reg_sel, `REG_SYSTEM_PIN_SELECT)) begin
      configured_q <= 2'h3;
    end
  end

  assign ss_func      = decode_func(1'b1, port_e_periph_q[`PORT_E_SS_LINE], 1'b0);
  assign phase_a_func = decode_func(configured_q[0], port_c_periph_q[`PORT_C_PHASE_A_LINE],
                                    pin_select_q[`PIN_SEL_PHASE_A_ALT_BIT]);
  assign phase_b_func = decode_func(configured_q[1], port_c_periph_q[`PORT_C_PHASE_B_LINE],
                                    pin_select_q[`PIN_SEL_PHASE_B_ALT_BIT]);

  pin_pad_cell u_ss_cell (
    .i_clock         (i_clock),
    .i_rst_b         (i_rst_b),
    .i_func          (ss_func),
    .i_prim_out      (1'b0),
    .i_prim_oe       (1'b0),
    .i_alt_out       (1'b0),
    .i_alt_oe        (1'b0),
    .i_gpio_out      (port_data_q[`DATA_PORT_E_BIT]),
    .i_gpio_oe       (port_e_dir_q[`PORT_E_SS_LINE]),
    .i_pullup_bit    (port_e_pullup_q[`PORT_E_SS_LINE]),
    .o_pad_out       (o_ss_pad_out),
    .o_pad_oe        (o_ss_pad_oe),
    .o_pad_pullup_en (o_ss_pad_pullup_en)
  );

  // Clock and data take matching one-cycle paths so their half-period offset survives
  pin_pad_cell u_phase_a_cell (
    .i_clock         (i_clock),
    .i_rst_b         (i_rst_b),
    .i_func          (phase_a_func),
    .i_prim_out      (i_timer_b_channel_0_out),
    .i_prim_oe       (i_timer_b_channel_0_oe),
    .i_alt_out       (i_spi1_sclk_out),
    .i_alt_oe        (i_spi1_master),
    .i_gpio_out      (port_data_q[`DATA_PORT_C0_BIT]),
    .i_gpio_oe       (port_c_dir_q[`PORT_C_PHASE_A_LINE]),
    .i_pullup_bit    (port_c_pullup_q[`PORT_C_PHASE_A_LINE]),
    .o_pad_out       (o_phase_a_pad_out),
    .o_pad_oe        (o_phase_a_pad_oe),
    .o_pad_pullup_en (o_phase_a_pad_pullup_en)
  );

  pin_pad_cell u_phase_b_cell (
    .i_clock         (i_clock),
    .i_rst_b         (i_rst_b),
    .i_func          (phase_b_func),
    .i_prim_out      (i_timer_b_channel_1_out),
    .i_prim_oe       (i_timer_b_channel_1_oe),
    .i_alt_out       (i_spi1_mosi_out),
    .i_alt_oe        (i_spi1_master),
    .i_gpio_out      (port_data_q[`DATA_PORT_C1_BIT]),
    .i_gpio_oe       (port_c_dir_q[`PORT_C_PHASE_B_LINE]),
    .i_pullup_bit    (port_c_pullup_q[`PORT_C_PHASE_B_LINE]),
    .o_pad_out       (o_phase_b_pad_out),
    .o_pad_oe        (o_phase_b_pad_oe),
    .o_pad_pullup_en (o_phase_b_pad_pullup_en)
  );

  // Deselected inputs idle: select high, everything else low
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_spi0_slave_select_pin_b <= 1'b1;
      o_spi0_receive_en         <= 1'b0;
    end else begin
      o_spi0_slave_select_pin_b <= (ss_func == pin_function_pkg::FUNC_PRIMARY) ? i_ss_pad_in : 1'b1;
      o_spi0_receive_en         <= (ss_func == pin_function_pkg::FUNC_PRIMARY) &
                                   ~i_spi0_master & ~i_ss_pad_in;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_spi1_serial_clock_pin <= 1'b0;
      o_spi1_data_out_pin     <= 1'b0;
    end else begin
      o_spi1_serial_clock_pin <= (phase_a_func == pin_function_pkg::FUNC_ALT_SPI) &
                                 ~i_spi1_master & i_phase_a_pad_in;
      o_spi1_data_out_pin     <= (phase_b_func == pin_function_pkg::FUNC_ALT_SPI) &
                                 ~i_spi1_master & i_phase_b_pad_in;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_decoder1_phase_a_in <= 1'b0;
      o_decoder1_phase_b_in <= 1'b0;
      o_timer_b_channel_0   <= 1'b0;
      o_timer_b_channel_1   <= 1'b0;
    end else begin
      o_decoder1_phase_a_in <= (phase_a_func == pin_function_pkg::FUNC_PRIMARY) & i_phase_a_pad_in;
      o_decoder1_phase_b_in <= (phase_b_func == pin_function_pkg::FUNC_PRIMARY) & i_phase_b_pad_in;
      o_timer_b_channel_0   <= (phase_a_func == pin_function_pkg::FUNC_PRIMARY) & i_phase_a_pad_in;
      o_timer_b_channel_1   <= (phase_b_func == pin_function_pkg::FUNC_PRIMARY) & i_phase_b_pad_in;
    end
  end

  // GPIO reads show the pad level in every function
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_port_e_line_7 <= 1'b0;
      o_port_c_line_0 <= 1'b0;
      o_port_c_line_1 <= 1'b0;
    end else begin
      o_port_e_line_7 <= i_ss_pad_in;
      o_port_c_line_0 <= i_phase_a_pad_in;
      o_port_c_line_1 <= i_phase_b_pad_in;
    end
  end

  assign o_system_pin_select_reg = pin_select_q;
  assign o_port_e_pullup_ctrl    = port_e_pullup_q;
  assign o_port_c_pullup_ctrl    = port_c_pullup_q;
  assign o_port_e_periph_en      = port_e_periph_q;
  assign o_port_c_periph_en      = port_c_periph_q;
  assign o_port_e_dir            = port_e_dir_q;
  assign o_port_c_dir            = port_c_dir_q;
  assign o_port_data             = port_data_q;
  assign o_phase_pins_configured = configured_q;

endmodule : pin_function_select

// >>> hdl/pin_pad_cell.sv
`timescale 1ns/1ps

module pin_pad_cell (
  input  logic                        i_clock,
  input  logic                        i_rst_b,
  input  pin_function_pkg::pin_func_e i_func,
  input  logic                        i_prim_out,
  input  logic                        i_prim_oe,
  input  logic                        i_alt_out,
  input  logic                        i_alt_oe,
  input  logic                        i_gpio_out,
  input  logic                        i_gpio_oe,
  input  logic                        i_pullup_bit,
  output logic                        o_pad_out,
  output logic                        o_pad_oe,
  output logic                        o_pad_pullup_en
);

  logic out_d;
  logic oe_d;

  always_comb begin
    out_d = 1'b0;
    oe_d  = 1'b0;
    case (i_func)
      pin_function_pkg::FUNC_PRIMARY: begin
        out_d = i_prim_out;
        oe_d  = i_prim_oe;
      end
      pin_function_pkg::FUNC_ALT_SPI: begin
        out_d = i_alt_out;
        oe_d  = i_alt_oe;
      end
      pin_function_pkg::FUNC_GPIO: begin
        out_d = i_gpio_out;
        oe_d  = i_gpio_oe;
      end
      default: begin
        out_d = 1'b0;
        oe_d  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_pad_out <= 1'b0;
      o_pad_oe  <= 1'b0;
    end else begin
      o_pad_out <= out_d;
      o_pad_oe  <= oe_d;
    end
  end

  // Pull-up held off while driving to avoid fighting the driver
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_pad_pullup_en <= 1'b1;
    end else begin
      o_pad_pullup_en <= i_pullup_bit & ~oe_d;
    end
  end

endmodule : pin_pad_cell

// >>> include/pin_function_defines.svh
`ifndef PIN_FUNCTION_DEFINES_SVH
`define PIN_FUNCTION_DEFINES_SVH

// Register select codes on the local write port
`define REG_SYSTEM_PIN_SELECT   3'h0
`define REG_PORT_E_PULLUP       3'h1
`define REG_PORT_C_PULLUP       3'h2
`define REG_PORT_E_PERIPH       3'h3
`define REG_PORT_C_PERIPH       3'h4
`define REG_PORT_E_DIR          3'h5
`define REG_PORT_C_DIR          3'h6
`define REG_PORT_DATA           3'h7

// Field positions
`define PIN_SEL_PHASE_A_ALT_BIT 0
`define PIN_SEL_PHASE_B_ALT_BIT 1
`define PORT_E_SS_LINE          7
`define PORT_C_PHASE_A_LINE     0
`define PORT_C_PHASE_B_LINE     1
`define DATA_PORT_E_BIT         0
`define DATA_PORT_C0_BIT        1
`define DATA_PORT_C1_BIT        2

// Reset values
`define PIN_SELECT_RESET        8'h00
`define PULLUP_RESET            8'hFF
`define PERIPH_RESET            8'hFF
`define DIR_RESET               8'h00
`define DATA_RESET              8'h00

`endif

// >>> include/pin_function_pkg.sv
package pin_function_pkg;

  typedef enum logic [1:0] {
    FUNC_NONE,
    FUNC_PRIMARY,
    FUNC_ALT_SPI,
    FUNC_GPIO
  } pin_func_e;

endpackage : pin_function_pkg

// >>> sim/pin_far_side.sv
`timescale 1ns/1ps
module pin_far_side (
  input  logic       i_clock,
  input  logic [2:0] i_pad_out,
  input  logic [2:0] i_pad_oe,
  input  logic [2:0] i_pad_pullup_en,
  input  logic [2:0] i_ext_en,
  input  logic [2:0] i_ext_val,
  output logic [2:0] o_pad_level
);
  logic [2:0] last_q;
  always_ff @(posedge i_clock) begin
    last_q <= o_pad_level;
  end
  // Floating pad flips, so a stale level never passes for data
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      o_pad_level[k] = i_pad_oe[k] ? i_pad_out[k] : i_ext_en[k] ? i_ext_val[k] :
                       i_pad_pullup_en[k] ? 1'b1 : ~last_q[k];
    end
  end
endmodule : pin_far_side

// >>> sim/pin_function_select_bench.sv
`timescale 1ns/1ps
`include "pin_function_defines.svh"
module pin_function_select_bench;
  logic       i_clock, i_rst_b, i_reg_we;
  logic [2:0] i_reg_sel, lvl, pout, poe, ppu, ext;
  logic [7:0] i_reg_wdata, drv, o;
  logic [7:0] rb [8];
  logic [7:0] sh [8];
  logic       o_spi0_slave_select_pin_b, o_spi0_receive_en, o_spi1_serial_clock_pin, o_spi1_data_out_pin;
  logic       o_decoder1_phase_a_in, o_decoder1_phase_b_in, o_timer_b_channel_0, o_timer_b_channel_1;
  logic       o_port_e_line_7, o_port_c_line_0, o_port_c_line_1;
  logic [1:0] o_phase_pins_configured, ea, eb, es;
  logic [2:0] pl;
  logic [1:0] cfg_s;
  logic       oe_s, dec_s, scfg;
  logic [31:0] r;
  int         mismatches, checks;

  pin_function_select #(.LARGE_VARIANT(1'b1)) i_dut (
    .i_clock, .i_rst_b, .i_reg_we, .i_reg_sel, .i_reg_wdata,
    .i_ss_pad_in(lvl[0]), .o_ss_pad_out(pout[0]), .o_ss_pad_oe(poe[0]), .o_ss_pad_pullup_en(ppu[0]),
    .i_phase_a_pad_in(lvl[1]), .o_phase_a_pad_out(pout[1]), .o_phase_a_pad_oe(poe[1]),
    .o_phase_a_pad_pullup_en(ppu[1]), .i_phase_b_pad_in(lvl[2]), .o_phase_b_pad_out(pout[2]),
    .o_phase_b_pad_oe(poe[2]), .o_phase_b_pad_pullup_en(ppu[2]), .i_spi0_master(drv[0]),
    .o_spi0_slave_select_pin_b, .o_spi0_receive_en, .i_spi1_master(drv[1]), .i_spi1_sclk_out(drv[2]),
    .i_spi1_mosi_out(drv[3]), .o_spi1_serial_clock_pin, .o_spi1_data_out_pin, .o_decoder1_phase_a_in,
    .o_decoder1_phase_b_in, .i_timer_b_channel_0_out(drv[4]), .i_timer_b_channel_0_oe(drv[5]),
    .i_timer_b_channel_1_out(drv[6]), .i_timer_b_channel_1_oe(drv[7]), .o_timer_b_channel_0,
    .o_timer_b_channel_1, .o_port_e_line_7, .o_port_c_line_0, .o_port_c_line_1,
    .o_system_pin_select_reg(rb[0]), .o_port_e_pullup_ctrl(rb[1]), .o_port_c_pullup_ctrl(rb[2]),
    .o_port_e_periph_en(rb[3]), .o_port_c_periph_en(rb[4]), .o_port_e_dir(rb[5]), .o_port_c_dir(rb[6]),
    .o_port_data(rb[7]), .o_phase_pins_configured);
  pin_far_side i_far (.i_clock, .i_pad_out(pout), .i_pad_oe(poe), .i_pad_pullup_en(ppu),
    .i_ext_en(3'h7), .i_ext_val(ext), .o_pad_level(lvl));
  // Small variant shares every input; only its phase A pad enable, phase A decoder input and both configured flags are watched
  pin_function_select #(.LARGE_VARIANT(1'b0)) i_dut_small (
    .i_clock, .i_rst_b, .i_reg_we, .i_reg_sel, .i_reg_wdata, .i_ss_pad_in(lvl[0]), .o_ss_pad_out(),
    .o_ss_pad_oe(), .o_ss_pad_pullup_en(), .i_phase_a_pad_in(lvl[1]), .o_phase_a_pad_out(),
    .o_phase_a_pad_oe(oe_s), .o_phase_a_pad_pullup_en(), .i_phase_b_pad_in(lvl[2]), .o_phase_b_pad_out(),
    .o_phase_b_pad_oe(), .o_phase_b_pad_pullup_en(), .i_spi0_master(drv[0]), .o_spi0_slave_select_pin_b(),
    .o_spi0_receive_en(), .i_spi1_master(drv[1]), .i_spi1_sclk_out(drv[2]), .i_spi1_mosi_out(drv[3]),
    .o_spi1_serial_clock_pin(), .o_spi1_data_out_pin(), .o_decoder1_phase_a_in(dec_s),
    .o_decoder1_phase_b_in(), .i_timer_b_channel_0_out(drv[4]), .i_timer_b_channel_0_oe(drv[5]),
    .i_timer_b_channel_1_out(drv[6]), .i_timer_b_channel_1_oe(drv[7]), .o_timer_b_channel_0(),
    .o_timer_b_channel_1(), .o_port_e_line_7(), .o_port_c_line_0(), .o_port_c_line_1(),
    .o_system_pin_select_reg(), .o_port_e_pullup_ctrl(), .o_port_c_pullup_ctrl(), .o_port_e_periph_en(),
    .o_port_c_periph_en(), .o_port_e_dir(), .o_port_c_dir(), .o_port_data(), .o_phase_pins_configured(cfg_s));

  always #50 i_clock = ~i_clock;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Pad drive pair {out, oe} from the pin's function
  function automatic logic [1:0] pexp(input logic per, alt, gd, gdir, sd, soe, td, toe);
    return !per ? {gd, gdir} : alt ? {sd, soe} : {td, toe};
  endfunction : pexp

  task automatic cmp1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask : cmp1
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask : cmp8
  task automatic wr(input logic [2:0] c, input logic [7:0] d);
    @(posedge i_clock);
    i_reg_we <= 1'b1;
    i_reg_sel <= c;
    i_reg_wdata <= d;
    @(posedge i_clock);
    i_reg_we <= 1'b0;
    sh[c] = d;
    if (c == `REG_SYSTEM_PIN_SELECT || c == `REG_PORT_C_PERIPH) scfg = 1'b1;
  endtask : wr
  task automatic chk_reset;
    sh = '{`PIN_SELECT_RESET, `PULLUP_RESET, `PULLUP_RESET, `PERIPH_RESET, `PERIPH_RESET,
           `DIR_RESET, `DIR_RESET, `DATA_RESET};
    #1;
    for (int k = 0; k < 8; k++) cmp8(rb[k], sh[k]);
    cmp1(o_spi0_slave_select_pin_b, 1'b1);
    cmp8({5'h00, ppu}, 8'h07);
    cmp8({6'h00, o_phase_pins_configured}, 8'h03);
    scfg = 1'b0;
    cmp8({6'h00, cfg_s}, 8'h00);
  endtask : chk_reset
  task automatic burst;
    for (int n = 0; n < 8; n++) begin
      @(posedge i_clock);
      o = drv;
      pl = lvl;
      r = lfsr(r);
      drv <= r[7:0];
      ext <= r[10:8];
      #1;
      ea = pexp(sh[4][0], sh[0][0], sh[7][1], sh[6][0], o[2], o[1], o[4], o[5]);
      eb = pexp(sh[4][1], sh[0][1], sh[7][2], sh[6][1], o[3], o[1], o[6], o[7]);
      es = sh[3][7] ? 2'b00 : {sh[7][0], sh[5][7]};
      cmp8({6'h00, pout[1], poe[1]}, {6'h00, ea});
      cmp8({6'h00, pout[2], poe[2]}, {6'h00, eb});
      cmp8({6'h00, pout[0], poe[0]}, {6'h00, es});
      cmp8({5'h00, ppu}, {5'h00, sh[2][1] & ~eb[0], sh[2][0] & ~ea[0], sh[1][7] & ~es[0]});
      cmp1(o_spi0_receive_en, sh[3][7] & ~o[0] & ~pl[0]);
      cmp1(o_spi0_slave_select_pin_b, sh[3][7] ? pl[0] : 1'b1);
      cmp1(o_spi1_serial_clock_pin, sh[4][0] & sh[0][0] & ~o[1] & pl[1]);
      cmp1(o_spi1_data_out_pin, sh[4][1] & sh[0][1] & ~o[1] & pl[2]);
      cmp1(o_decoder1_phase_a_in, sh[4][0] & ~sh[0][0] & pl[1]);
      cmp1(o_timer_b_channel_1, sh[4][1] & ~sh[0][1] & pl[2]);
      cmp1(o_timer_b_channel_0, sh[4][0] & ~sh[0][0] & pl[1]);
      cmp1(o_decoder1_phase_b_in, sh[4][1] & ~sh[0][1] & pl[2]);
      cmp8({4'h0, cfg_s, oe_s, dec_s}, {4'h0, {2{scfg}}, scfg & ea[0], scfg & sh[4][0] & ~sh[0][0] & pl[1]});
      cmp8({5'h00, o_port_c_line_1, o_port_c_line_0, o_port_e_line_7}, {5'h00, pl[2:0]});
    end
  endtask : burst
  task automatic summarize;
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  initial begin
    i_clock = 1'b0;
    i_rst_b = 1'b0;
    i_reg_we = 1'b0;
    i_reg_sel = 3'h0;
    i_reg_wdata = 8'h00;
    drv = 8'h00;
    ext = 3'h0;
    r = 32'h7b0a;
    repeat (2) @(posedge i_clock);
    i_rst_b <= 1'b1;
    chk_reset;
    burst;
    for (int k = 0; k < 8; k++) begin
      r = lfsr(r);
      wr(k[2:0], r[15:8]);
      #1;
      cmp8(rb[k], sh[k]);
    end
    // Corner: both alternates with every pull-up cleared
    wr(3'h0, 8'h03);
    wr(3'h4, 8'hFF);
    wr(3'h2, 8'h00);
    wr(3'h1, 8'h00);
    burst;
    for (int n = 0; n < 12; n++) begin
      for (int k = 0; k < 8; k++) begin
        r = lfsr(r);
        wr(k[2:0], r[23:16]);
      end
      burst;
    end
    @(posedge i_clock);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rst_b <= 1'b1;
    chk_reset;
    burst;
    summarize;
  end
  initial begin
    repeat (3000) @(posedge i_clock);
    mismatches++;
    summarize;
  end
endmodule : pin_function_select_bench

bind pin_function_select pin_function_select_checker i_chk (
  .i_clock, .i_rst_b, .i_reg_we, .i_reg_sel, .i_reg_wdata, .i_ss_pad_in, .o_ss_pad_pullup_en,
  .i_phase_a_pad_in, .o_phase_a_pad_out, .o_phase_a_pad_oe, .o_phase_a_pad_pullup_en,
  .o_phase_b_pad_out, .o_phase_b_pad_oe, .i_spi0_master, .o_spi0_slave_select_pin_b,
  .o_spi0_receive_en, .i_spi1_master, .i_spi1_sclk_out, .i_spi1_mosi_out, .o_spi1_serial_clock_pin,
  .o_decoder1_phase_a_in, .o_system_pin_select_reg, .o_port_e_pullup_ctrl, .o_port_c_pullup_ctrl,
  .o_port_e_periph_en, .o_port_c_periph_en, .o_phase_pins_configured);

// >>> sim/pin_function_select_checker.sv
`timescale 1ns/1ps
module pin_function_select_checker (
  input logic       i_clock,
  input logic       i_rst_b,
  input logic       i_reg_we,
  input logic [2:0] i_reg_sel,
  input logic [7:0] i_reg_wdata,
  input logic       i_ss_pad_in,
  input logic       o_ss_pad_pullup_en,
  input logic       i_phase_a_pad_in,
  input logic       o_phase_a_pad_out,
  input logic       o_phase_a_pad_oe,
  input logic       o_phase_a_pad_pullup_en,
  input logic       o_phase_b_pad_out,
  input logic       o_phase_b_pad_oe,
  input logic       i_spi0_master,
  input logic       o_spi0_slave_select_pin_b,
  input logic       o_spi0_receive_en,
  input logic       i_spi1_master,
  input logic       i_spi1_sclk_out,
  input logic       i_spi1_mosi_out,
  input logic       o_spi1_serial_clock_pin,
  input logic       o_decoder1_phase_a_in,
  input logic [7:0] o_system_pin_select_reg,
  input logic [7:0] o_port_e_pullup_ctrl,
  input logic [7:0] o_port_c_pullup_ctrl,
  input logic [7:0] o_port_e_periph_en,
  input logic [7:0] o_port_c_periph_en,
  input logic [1:0] o_phase_pins_configured
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  sequence s_alt_a;
    o_phase_pins_configured[0] && o_port_c_periph_en[0] && o_system_pin_select_reg[0];
  endsequence
  sequence s_alt_b;
    o_phase_pins_configured[1] && o_port_c_periph_en[1] && o_system_pin_select_reg[1];
  endsequence
  property p_wr_sel;
    i_reg_we && i_reg_sel == 3'h0 |=> o_system_pin_select_reg == $past(i_reg_wdata);
  endproperty
  property p_rst;
    $rose(i_rst_b) |-> o_system_pin_select_reg == 8'h00 && o_spi0_slave_select_pin_b && o_ss_pad_pullup_en;
  endproperty
  property p_ss_pu;
    !o_port_e_pullup_ctrl[7] |=> !o_ss_pad_pullup_en;
  endproperty
  property p_pa_pu;
    !o_port_c_pullup_ctrl[0] |=> !o_phase_a_pad_pullup_en;
  endproperty
  property p_alt_a;
    s_alt_a |=> o_phase_a_pad_out == $past(i_spi1_sclk_out) && o_phase_a_pad_oe == $past(i_spi1_master);
  endproperty
  property p_alt_b;
    s_alt_b |=> o_phase_b_pad_out == $past(i_spi1_mosi_out) && o_phase_b_pad_oe == $past(i_spi1_master);
  endproperty
  property p_sclk_in;
    s_alt_a ##0 !i_spi1_master |=> o_spi1_serial_clock_pin == $past(i_phase_a_pad_in);
  endproperty
  property p_recv;
    o_port_e_periph_en[7] && !i_spi0_master && !i_ss_pad_in |=> o_spi0_receive_en && !o_spi0_slave_select_pin_b;
  endproperty
  property p_none;
    !o_phase_pins_configured[0] |=> !o_phase_a_pad_oe && !o_decoder1_phase_a_in;
  endproperty
  property p_dec;
    o_phase_pins_configured[0] && o_port_c_periph_en[0] && !o_system_pin_select_reg[0]
      |=> o_decoder1_phase_a_in == $past(i_phase_a_pad_in);
  endproperty
  a_wr_sel: assert property (p_wr_sel) else $error("pin select write lost");
  a_rst: assert property (p_rst) else $error("bad value out of reset");
  a_ss_pu: assert property (p_ss_pu) else $error("select pad pull-up on");
  a_pa_pu: assert property (p_pa_pu) else $error("phase A pull-up on");
  a_alt_a: assert property (p_alt_a) else $error("phase A clock drive wrong");
  a_alt_b: assert property (p_alt_b) else $error("phase B data drive wrong");
  a_sclk_in: assert property (p_sclk_in) else $error("slave clock input wrong");
  a_recv: assert property (p_recv) else $error("select not received");
  a_dec: assert property (p_dec) else $error("decoder input wrong");
  a_none: assert property (p_none) else $error("unassigned phase pin active");
endmodule : pin_function_select_checker
